/* File: verilog/cmsr_top.sv */
// clocking mode select, reference clock output generator and legacy parallel format registers
`timescale 1ns/1ps
`default_nettype none
`include "cmsr_map.svh"

module cmsr_top (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  power_enable_pin,
  input  wire logic [2:0]            mode_strap,
  input  wire logic                  address_strap_pin,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  input  wire logic                  pkt_valid,
  input  wire logic [5:0]            pkt_dt,
  output logic                       pkt_pass,
  output var cmsr_pkg::cmsr_ref_src_t refclk_source,
  output logic                       always_on_oscillator_en,
  output logic                       osc_full_rate_select,
  output logic [7:0]                 link_rate_mult,
  output logic                       clk_out_enable,
  output logic                       ref_clk_out,
  output logic                       legacy_parallel_compat,
  output logic [1:0]                 legacy_format
);
  import cmsr_pkg::*;

  logic       pe_reg;
  logic [2:0] strap_mode_reg;
  logic       addr_strap_reg;
  logic       override_reg;
  logic [2:0] sw_mode_reg;
  logic [2:0] active_mode;
  logic [1:0] fmt_reg;
  logic       osc_full_reg;
  logic [2:0] hsdiv_reg;
  logic [4:0] mul_reg;
  logic [7:0] den_reg;
  logic [2:0] pcfg_reg;
  logic [5:0] pdt_reg;
  logic [12:0] acc_reg;
  logic [12:0] acc_next;
  logic [12:0] period;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [6:0] dev_addr;
  logic       fmt_match;

  // decode of a mode code into its reference source
  function automatic cmsr_ref_src_t mode_source(input logic [2:0] m);
    unique case (m)
      `CMSR_MODE_EXT, `CMSR_MODE_LEGACY: mode_source = CMSR_SRC_EXTERNAL;
      `CMSR_MODE_INT:                    mode_source = CMSR_SRC_INTERNAL;
      default:                           mode_source = CMSR_SRC_BACK_CHANNEL;
    endcase
  endfunction

  function automatic logic [7:0] mode_rate(input logic [2:0] m);
    unique case (m)
      `CMSR_MODE_EXT, `CMSR_MODE_INT: mode_rate = `CMSR_RATE_NONSYNC;
      `CMSR_MODE_LEGACY:              mode_rate = `CMSR_RATE_LEGACY;
      default:                        mode_rate = `CMSR_RATE_SYNC;
    endcase
  endfunction

  // divider code n means divide by 2**n; codes above 4 are clamped to 16
  function automatic logic [4:0] hsdiv_value(input logic [2:0] c);
    hsdiv_value = (c > 3'h4) ? 5'h10 : 5'(5'h01 << c);
  endfunction

  // strap caught by a clocked edge detector, never by the reset itself
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pe_reg         <= 1'b0;
      strap_mode_reg <= `CMSR_MODE_SYNC;
      addr_strap_reg <= 1'b0;
    end
    else
    begin
      pe_reg <= power_enable_pin;
      if (power_enable_pin && !pe_reg)
      begin
        strap_mode_reg <= mode_strap;
        addr_strap_reg <= address_strap_pin;
      end
    end
  end

  assign dev_addr = addr_strap_reg ? `CMSR_I2C_ADDR_HIGH : `CMSR_I2C_ADDR_LOW;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      override_reg <= 1'b0;
      sw_mode_reg  <= `CMSR_MODE_SYNC;
    end
    else if (wr_en && wr_addr == `CMSR_OFS_MODE)
    begin
      override_reg <= wr_data[`CMSR_MODE_OVR_BIT];
      // the field takes the written value only in a write that holds override high; otherwise it reloads the strap mode
      if (wr_data[`CMSR_MODE_OVR_BIT])
        sw_mode_reg <= wr_data[`CMSR_MODE_MSB:0];
      else
        sw_mode_reg <= strap_mode_reg;
    end
  end

  assign active_mode = override_reg ? sw_mode_reg : strap_mode_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      fmt_reg <= `CMSR_FMT_NONE;
    else if (wr_en && wr_addr == `CMSR_OFS_FMT && wr_data[1:0] != `CMSR_FMT_RAW12_LOW_FREQ_FORMAT)
      fmt_reg <= wr_data[1:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      osc_full_reg <= 1'b0;
      hsdiv_reg    <= `CMSR_HSDIV_RST;
      mul_reg      <= `CMSR_MUL_RST;
      den_reg      <= `CMSR_DEN_RST;
    end
    else if (wr_en)
    begin
      if (wr_addr == `CMSR_OFS_OSC)
        osc_full_reg <= wr_data[`CMSR_OSC_FULL_BIT];
      if (wr_addr == `CMSR_OFS_CLKMUL)
      begin
        hsdiv_reg <= wr_data[`CMSR_HSDIV_MSB:`CMSR_HSDIV_LSB];
        mul_reg   <= wr_data[`CMSR_MUL_MSB:0];
      end
      // zero denominator would make the generator toggle every clock, so it is refused
      if (wr_addr == `CMSR_OFS_CLKDIV && wr_data != 8'h00)
        den_reg <= wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pcfg_reg <= `CMSR_PCFG_RST;
      pdt_reg  <= `CMSR_PDT_RST;
    end
    else if (wr_en)
    begin
      if (wr_addr == `CMSR_OFS_PCFG)
        pcfg_reg <= wr_data[2:0];
      if (wr_addr == `CMSR_OFS_PDT)
        pdt_reg <= wr_data[`CMSR_DT_MSB:0];
    end
  end

  always_comb
  begin
    unique case (rd_addr)
      `CMSR_OFS_MODE:   rd_data = {3'h0, override_reg, 1'b0, active_mode};
      `CMSR_OFS_FMT:    rd_data = {6'h00, fmt_reg};
      `CMSR_OFS_OSC:    rd_data = {4'h0, osc_full_reg, 3'h0};
      `CMSR_OFS_CLKMUL: rd_data = {hsdiv_reg, mul_reg};
      `CMSR_OFS_CLKDIV: rd_data = den_reg;
      `CMSR_OFS_PCFG:   rd_data = {5'h00, pcfg_reg};
      `CMSR_OFS_PDT:    rd_data = {2'h0, pdt_reg};
      default:          rd_data = 8'h00;
    endcase
  end

  // clk stands in for the link bit rate; one full output period spans div*N/M clocks,
  // so each half period needs the accumulator to gain 2*M per clock
  assign period   = {8'h00, hsdiv_value(hsdiv_reg)} * {5'h00, den_reg};
  assign acc_next = acc_reg + {7'h00, mul_reg, 1'b0};

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      acc_reg     <= 13'h0000;
      ref_clk_out <= 1'b0;
    end
    else if (!clk_out_enable)
    begin
      acc_reg     <= 13'h0000;
      ref_clk_out <= 1'b0;
    end
    else if (acc_next >= period)
    begin
      // a remainder of a whole period or more would need several toggles a cycle; it toggles once and the accumulator clears to zero instead
      acc_reg     <= (acc_next - period >= period) ? 13'h0000 : 13'(acc_next - period);
      ref_clk_out <= ~ref_clk_out;
    end
    else
      acc_reg <= acc_next;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      refclk_source           <= CMSR_SRC_BACK_CHANNEL;
      always_on_oscillator_en <= 1'b0;
      link_rate_mult          <= `CMSR_RATE_SYNC;
      clk_out_enable          <= 1'b0;
      legacy_parallel_compat  <= 1'b0;
      osc_full_rate_select    <= 1'b0;
      legacy_format           <= `CMSR_FMT_NONE;
    end
    else
    begin
      refclk_source           <= mode_source(active_mode);
      always_on_oscillator_en <= (mode_source(active_mode) == CMSR_SRC_INTERNAL);
      link_rate_mult          <= mode_rate(active_mode);
      clk_out_enable          <= (mode_source(active_mode) != CMSR_SRC_INTERNAL);
      legacy_parallel_compat  <= (active_mode == `CMSR_MODE_LEGACY);
      osc_full_rate_select    <= osc_full_reg;
      legacy_format           <= fmt_reg;
    end
  end

  always_comb
  begin
    unique case (fmt_reg)
      `CMSR_FMT_RAW10:    fmt_match = (pkt_dt == `CMSR_DT_RAW10);
      `CMSR_FMT_RAW12_HIGH_FREQ_FORMAT: fmt_match = (pkt_dt == `CMSR_DT_RAW12);
      default:            fmt_match = (pkt_dt == `CMSR_DT_RAW10) || (pkt_dt == `CMSR_DT_RAW12);
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pkt_pass <= 1'b0;
    else
      pkt_pass <= pkt_valid && legacy_parallel_compat &&
                  (fmt_match ||
                   (pcfg_reg[`CMSR_PCFG_LONG_BIT] && pkt_dt >= `CMSR_DT_LONG_MIN) ||
                   (pcfg_reg[`CMSR_PCFG_YUV_BIT] && pkt_dt >= `CMSR_DT_YUV_MIN &&
                    pkt_dt <= `CMSR_DT_YUV_MAX) ||
                   (pcfg_reg[`CMSR_PCFG_MATCH_BIT] && pkt_dt == pdt_reg));
  end

  cmsr_i2c_target u_i2c (
    .clk      (clk),
    .rst_n    (rst_n),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .dev_addr (dev_addr),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .wr_en    (wr_en),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data)
  );
endmodule // cmsr_top

`default_nettype wire

/* File: shared/cmsr_map.svh */
// register offsets, field positions, reset values and codes of the clock mode block
`ifndef CMSR_MAP_SVH
`define CMSR_MAP_SVH

`define CMSR_OFS_MODE        8'h03
`define CMSR_OFS_FMT         8'h04
`define CMSR_OFS_OSC         8'h05
`define CMSR_OFS_CLKMUL      8'h06
`define CMSR_OFS_CLKDIV      8'h07
`define CMSR_OFS_PCFG        8'h10
`define CMSR_OFS_PDT         8'h11

`define CMSR_MODE_MSB        2
`define CMSR_MODE_OVR_BIT    4
`define CMSR_OSC_FULL_BIT    3
`define CMSR_HSDIV_MSB       7
`define CMSR_HSDIV_LSB       5
`define CMSR_MUL_MSB         4
`define CMSR_PCFG_LONG_BIT   0
`define CMSR_PCFG_YUV_BIT    1
`define CMSR_PCFG_MATCH_BIT  2
`define CMSR_DT_MSB          5

`define CMSR_MODE_SYNC       3'h0
`define CMSR_MODE_EXT        3'h2
`define CMSR_MODE_INT        3'h3
`define CMSR_MODE_LEGACY     3'h5

`define CMSR_RATE_SYNC       8'ha0
`define CMSR_RATE_NONSYNC    8'h50
`define CMSR_RATE_LEGACY     8'h1c

`define CMSR_FMT_NONE        2'h0
`define CMSR_FMT_RAW10       2'h1
`define CMSR_FMT_RAW12_HIGH_FREQ_FORMAT    2'h2
`define CMSR_FMT_RAW12_LOW_FREQ_FORMAT    2'h3

`define CMSR_HSDIV_RST       3'h2
`define CMSR_MUL_RST         5'h01
`define CMSR_DEN_RST         8'h01
`define CMSR_PCFG_RST        3'h0
`define CMSR_PDT_RST         6'h00

`define CMSR_DT_LONG_MIN     6'h10
`define CMSR_DT_YUV_MIN      6'h18
`define CMSR_DT_YUV_MAX      6'h1f
`define CMSR_DT_RAW10        6'h2b
`define CMSR_DT_RAW12        6'h2c

`define CMSR_I2C_ADDR_LOW    7'h18
`define CMSR_I2C_ADDR_HIGH   7'h19
`define CMSR_BIT_CNT_BYTE    4'h8

`endif

/* File: shared/cmsr_pkg.sv */
// types shared by the clock mode block
package cmsr_pkg;
  typedef enum logic [1:0] {
    CMSR_SRC_BACK_CHANNEL,
    CMSR_SRC_EXTERNAL,
    CMSR_SRC_INTERNAL
  } cmsr_ref_src_t;

  typedef enum logic [3:0] {
    CMSR_ST_IDLE,
    CMSR_ST_ADDR,
    CMSR_ST_ADDR_ACK,
    CMSR_ST_PTR,
    CMSR_ST_PTR_ACK,
    CMSR_ST_WDATA,
    CMSR_ST_WDATA_ACK,
    CMSR_ST_RDATA,
    CMSR_ST_RACK
  } cmsr_i2c_state_t;
endpackage

/* File: verilog/cmsr_i2c_target.sv */
// serial control bus target: address match, register pointer, byte writes and reads
`timescale 1ns/1ps
`default_nettype none
`include "cmsr_map.svh"

module cmsr_i2c_target (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic [6:0] dev_addr,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            wr_en,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data
);
  import cmsr_pkg::*;

  cmsr_i2c_state_t state_reg;
  logic            scl_reg;
  logic            sda_reg;
  logic [7:0]      shift_reg;
  logic [3:0]      cnt_reg;
  logic [7:0]      ptr_reg;
  logic            is_read_reg;
  logic            nack_reg;
  logic            start_det;
  logic            stop_det;
  logic            scl_rise;
  logic            scl_fall;
  logic            byte_done;

  // open drain: only ever pulls low
  assign sda_out   = 1'b0;
  assign start_det = scl_in & scl_reg & sda_reg & ~sda_in;
  assign stop_det  = scl_in & scl_reg & ~sda_reg & sda_in;
  assign scl_rise  = scl_in & ~scl_reg;
  assign scl_fall  = ~scl_in & scl_reg;
  assign byte_done = scl_fall && (cnt_reg == `CMSR_BIT_CNT_BYTE);
  assign wr_addr   = ptr_reg;
  assign wr_data   = shift_reg;
  assign rd_addr   = ptr_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end
    else
    begin
      scl_reg <= scl_in;
      sda_reg <= sda_in;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wr_en <= 1'b0;
    else
      wr_en <= (state_reg == CMSR_ST_WDATA) && byte_done && !start_det && !stop_det;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg   <= CMSR_ST_IDLE;
      shift_reg   <= 8'h00;
      cnt_reg     <= 4'h0;
      ptr_reg     <= 8'h00;
      is_read_reg <= 1'b0;
      nack_reg    <= 1'b0;
      sda_oe      <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg <= CMSR_ST_ADDR;
      cnt_reg   <= 4'h0;
      sda_oe    <= 1'b0;
    end
    else if (stop_det)
    begin
      state_reg <= CMSR_ST_IDLE;
      sda_oe    <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        CMSR_ST_IDLE:
          sda_oe <= 1'b0;
        CMSR_ST_ADDR, CMSR_ST_PTR, CMSR_ST_WDATA:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_in};
            cnt_reg   <= cnt_reg + 4'h1;
          end
          else if (byte_done)
          begin
            cnt_reg <= 4'h0;
            if (state_reg == CMSR_ST_ADDR)
            begin
              if (shift_reg[7:1] == dev_addr)
              begin
                sda_oe      <= 1'b1;
                is_read_reg <= shift_reg[0];
                state_reg   <= CMSR_ST_ADDR_ACK;
              end
              else
                state_reg <= CMSR_ST_IDLE;
            end
            else if (state_reg == CMSR_ST_PTR)
            begin
              ptr_reg   <= shift_reg;
              sda_oe    <= 1'b1;
              state_reg <= CMSR_ST_PTR_ACK;
            end
            else
            begin
              sda_oe    <= 1'b1;
              state_reg <= CMSR_ST_WDATA_ACK;
            end
          end
        end
        CMSR_ST_ADDR_ACK, CMSR_ST_RACK:
        begin
          if (scl_rise && state_reg == CMSR_ST_RACK)
            nack_reg <= sda_in;
          if (scl_fall)
          begin
            if (state_reg == CMSR_ST_RACK && nack_reg)
            begin
              sda_oe    <= 1'b0;
              state_reg <= CMSR_ST_IDLE;
            end
            else if (state_reg == CMSR_ST_RACK || is_read_reg)
            begin
              // first bit goes out as soon as the acknowledge clock ends
              shift_reg <= rd_data;
              sda_oe    <= ~rd_data[7];
              ptr_reg   <= ptr_reg + 8'h01;
              cnt_reg   <= 4'h1;
              state_reg <= CMSR_ST_RDATA;
            end
            else
            begin
              sda_oe    <= 1'b0;
              state_reg <= CMSR_ST_PTR;
            end
          end
        end
        CMSR_ST_PTR_ACK, CMSR_ST_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            sda_oe    <= 1'b0;
            state_reg <= CMSR_ST_WDATA;
            if (state_reg == CMSR_ST_WDATA_ACK)
              ptr_reg <= ptr_reg + 8'h01;
          end
        end
        CMSR_ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (cnt_reg == `CMSR_BIT_CNT_BYTE)
            begin
              sda_oe    <= 1'b0;
              cnt_reg   <= 4'h0;
              state_reg <= CMSR_ST_RACK;
            end
            else
            begin
              sda_oe    <= ~shift_reg[6];
              shift_reg <= {shift_reg[6:0], 1'b0};
              cnt_reg   <= cnt_reg + 4'h1;
            end
          end
        end
        default:
          state_reg <= CMSR_ST_IDLE;
      endcase
    end
  end
endmodule // cmsr_i2c_target

`default_nettype wire

/* File: test/cmsr_top_checker.sv */
// concurrent checks on the clock mode block ports
`timescale 1ns/1ps
`default_nettype none
`include "cmsr_map.svh"
module cmsr_top_checker (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    power_enable_pin,
  input wire logic [2:0]              mode_strap,
  input wire logic                    address_strap_pin,
  input wire logic                    scl_in,
  input wire logic                    sda_in,
  input wire logic                    sda_out,
  input wire logic                    sda_oe,
  input wire logic                    pkt_valid,
  input wire logic [5:0]              pkt_dt,
  input wire logic                    pkt_pass,
  input wire cmsr_pkg::cmsr_ref_src_t refclk_source,
  input wire logic                    always_on_oscillator_en,
  input wire logic                    osc_full_rate_select,
  input wire logic [7:0]              link_rate_mult,
  input wire logic                    clk_out_enable,
  input wire logic                    ref_clk_out,
  input wire logic                    legacy_parallel_compat,
  input wire logic [1:0]              legacy_format
);
  import cmsr_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_osc_internal: assert property (always_on_oscillator_en == (refclk_source == CMSR_SRC_INTERNAL))
    else $error("oscillator enable and source disagree");
  a_clkout_internal: assert property (refclk_source == CMSR_SRC_INTERNAL |-> !clk_out_enable)
    else $error("clock output enabled in internal mode");
  a_refout_quiet: assert property (!clk_out_enable ##1 !clk_out_enable |-> !ref_clk_out)
    else $error("clock output moves while disabled");
  a_rate_sync: assert property (refclk_source == CMSR_SRC_BACK_CHANNEL |-> link_rate_mult == 8'ha0)
    else $error("wrong rate in synchronous mode");
  a_rate_nonsync: assert property (refclk_source != CMSR_SRC_BACK_CHANNEL && !legacy_parallel_compat
    |-> link_rate_mult == 8'h50)
    else $error("wrong rate in non-synchronous mode");
  a_legacy_clocking: assert property (legacy_parallel_compat |-> link_rate_mult == 8'h1c
    && refclk_source == CMSR_SRC_EXTERNAL && clk_out_enable)
    else $error("legacy mode clocking wrong");
  a_fmt_no_low: assert property (legacy_format != `CMSR_FMT_RAW12_LOW_FREQ_FORMAT)
    else $error("unsupported format selected");
  a_pass_cause: assert property (pkt_pass |-> $past(pkt_valid) && $past(legacy_parallel_compat))
    else $error("packet passed without legacy request");
  a_pass_raw12: assert property (pkt_valid && legacy_parallel_compat && legacy_format == 2'h2
    && pkt_dt == 6'h2c |=> pkt_pass)
    else $error("matching format packet dropped");
  a_sda_open: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  c_legacy: cover property (legacy_parallel_compat);
  c_internal: cover property (refclk_source == CMSR_SRC_INTERNAL);
  c_pass: cover property (pkt_pass);
  c_ack: cover property ($rose(sda_oe));
endmodule // cmsr_top_checker
bind cmsr_top cmsr_top_checker cmsr_top_checker_i (
  .clk(clk), .rst_n(rst_n), .power_enable_pin(power_enable_pin), .mode_strap(mode_strap),
  .address_strap_pin(address_strap_pin), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .pkt_valid(pkt_valid), .pkt_dt(pkt_dt), .pkt_pass(pkt_pass),
  .refclk_source(refclk_source), .always_on_oscillator_en(always_on_oscillator_en),
  .osc_full_rate_select(osc_full_rate_select), .link_rate_mult(link_rate_mult),
  .clk_out_enable(clk_out_enable), .ref_clk_out(ref_clk_out),
  .legacy_parallel_compat(legacy_parallel_compat), .legacy_format(legacy_format));
`default_nettype wire

/* File: test/cmsr_host_model.sv */
// serial control bus controller that configures the block
`timescale 1ns/1ps
`default_nettype none
module cmsr_host_model (
  input  wire logic       clk,
  input  wire logic       sda_oe,
  input  wire logic [6:0] dev_addr,
  output logic            scl_in,
  output logic            sda_in
);
  logic sda_drv;
  // pulled-up wire: whoever pulls low wins, so a released line reads 1
  assign sda_in = sda_drv & ~sda_oe;
  initial
  begin
    scl_in = 1'b1;
    sda_drv = 1'b1;
  end
  // three clocks per step (two steps low, one high) keeps both scl phases above the two-clock minimum
  task automatic step(input logic s, input logic d);
    repeat (3) @(posedge clk);
    scl_in <= s;
    sda_drv <= d;
  endtask
  // data changes only while scl is low, never on the falling edge itself
  task automatic xbit(input logic d, output logic q);
    step(1'b0, sda_drv);
    step(1'b0, d);
    step(1'b1, d);
    @(posedge clk);
    q = sda_in;
  endtask
  task automatic start;
    step(1'b0, sda_drv);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
  task automatic stop;
    step(1'b0, sda_drv);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  task automatic xbyte(input logic [7:0] d, input logic ackv, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--)
      xbit(d[i], q[i]);
    xbit(ackv, nak);
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       n0, n1, n2;
    start();
    xbyte({dev_addr, 1'b0}, 1'b1, q, n0);
    xbyte(a, 1'b1, q, n1);
    xbyte(d, 1'b1, q, n2);
    stop();
    ok = !(n0 | n1 | n2);
  endtask
  // single byte read, ended by a not-acknowledge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       n0, n1, n2, n3;
    start();
    xbyte({dev_addr, 1'b0}, 1'b1, q, n0);
    xbyte(a, 1'b1, q, n1);
    start();
    xbyte({dev_addr, 1'b1}, 1'b1, q, n2);
    xbyte(8'hff, 1'b1, d, n3);
    stop();
    ok = !(n0 | n1 | n2);
  endtask
endmodule // cmsr_host_model
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench for the clock mode block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cmsr_pkg::*;
  typedef struct packed {
    logic [2:0]    mode;
    cmsr_ref_src_t src;
    logic          clkout;
    logic [7:0]    mult;
    logic          legacy;
  } cmsr_row_t;
  logic          clk = 1'b0, rst_n = 1'b0, pwr = 1'b0, addr_strap = 1'b0, pkt_valid = 1'b0;
  logic [2:0]    strap = 3'h5;
  logic [5:0]    pkt_dt = 6'h00;
  logic [6:0]    dev_addr = 7'h18;
  logic          scl_in, sda_in, sda_out, sda_oe, pkt_pass, osc_en, osc_full, clk_out_enable, ref_clk_out;
  logic          legacy, ok;
  logic [7:0]    mult, rd;
  logic [1:0]    fmt;
  cmsr_ref_src_t src;
  int            error_cnt = 0, checks_done = 0;
  cmsr_row_t     rows [5] = '{'{3'h0, CMSR_SRC_BACK_CHANNEL, 1'b1, 8'ha0, 1'b0},
    '{3'h2, CMSR_SRC_EXTERNAL, 1'b1, 8'h50, 1'b0}, '{3'h3, CMSR_SRC_INTERNAL, 1'b0, 8'h50, 1'b0},
    '{3'h5, CMSR_SRC_EXTERNAL, 1'b1, 8'h1c, 1'b1}, '{3'h7, CMSR_SRC_BACK_CHANNEL, 1'b1, 8'ha0, 1'b0}};
  always #20 clk = ~clk;
  cmsr_top cmsr_top_i (.clk(clk), .rst_n(rst_n), .power_enable_pin(pwr), .mode_strap(strap),
    .address_strap_pin(addr_strap), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .pkt_valid(pkt_valid), .pkt_dt(pkt_dt), .pkt_pass(pkt_pass), .refclk_source(src),
    .always_on_oscillator_en(osc_en), .osc_full_rate_select(osc_full), .link_rate_mult(mult),
    .clk_out_enable(clk_out_enable), .ref_clk_out(ref_clk_out), .legacy_parallel_compat(legacy),
    .legacy_format(fmt));
  cmsr_host_model cmsr_host_model_i (.clk(clk), .sda_oe(sda_oe), .dev_addr(dev_addr), .scl_in(scl_in),
    .sda_in(sda_in));
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cmsr_host_model_i.write_reg(a, d, ok);
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic rg(input logic [7:0] a);
    cmsr_host_model_i.read_reg(a, rd, ok);
    #1;
  endtask
  task automatic pkt(input logic [5:0] dt, input logic exp);
    @(posedge clk);
    pkt_valid <= 1'b1;
    pkt_dt <= dt;
    @(posedge clk);
    pkt_valid <= 1'b0;
    #1 chk("pkt_pass", {7'h0, exp}, {7'h0, pkt_pass});
  endtask
  // output period only approximates div*N/M clocks, hence a window
  task automatic toggles(input string nm, input int lo, input int hi);
    logic p;
    int   n;
    n = 0;
    p = ref_clk_out;
    repeat (80)
    begin
      @(posedge clk);
      #1 n += (ref_clk_out !== p);
      p = ref_clk_out;
    end
    checks_done++;
    if (n < lo || n > hi)
    begin
      error_cnt++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, n);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("rate_rst", 8'ha0, mult);
    chk("legacy_rst", 8'h00, {7'h0, legacy});
    @(posedge clk);
    pwr <= 1'b1;
    repeat (4) @(posedge clk);
    rg(8'h03);
    chk("strap", 8'h05, {5'h00, rd[2:0]});
    chk("legacy_strap", 8'h01, {7'h0, legacy});
    wr(8'h03, 8'h03);
    rg(8'h03);
    chk("locked_mode", 8'h05, {5'h00, rd[2:0]});
    foreach (rows[i])
    begin
      wr(8'h03, {4'h1, 1'b0, rows[i].mode});
      rg(8'h03);
      chk("mode", {5'h00, rows[i].mode}, {5'h00, rd[2:0]});
      chk("src", 8'(rows[i].src), 8'(src));
      chk("clkout", {7'h0, rows[i].clkout}, {7'h0, clk_out_enable});
      chk("osc_en", {7'h0, rows[i].mode == 3'h3}, {7'h0, osc_en});
      chk("mult", rows[i].mult, mult);
      chk("legacy", {7'h0, rows[i].legacy}, {7'h0, legacy});
    end
    wr(8'h06, 8'h41);
    wr(8'h07, 8'h01);
    toggles("tog_m1", 36, 44);
    wr(8'h06, 8'h42);
    toggles("tog_m2", 76, 80);
    wr(8'h03, 8'h13);
    toggles("tog_int", 0, 0);
    wr(8'h05, 8'h08);
    chk("osc_full", 8'h01, {7'h0, osc_full});
    wr(8'h04, 8'h01);
    chk("fmt_raw10", 8'h01, {6'h00, fmt});
    wr(8'h04, 8'h03);
    chk("fmt_low", 8'h01, {6'h00, fmt});
    wr(8'h04, 8'h02);
    chk("fmt_raw12", 8'h02, {6'h00, fmt});
    wr(8'h03, 8'h15);
    pkt(6'h2c, 1'b1);
    pkt(6'h2b, 1'b0);
    wr(8'h11, 8'h2b);
    wr(8'h10, 8'h04);
    rg(8'h11);
    chk("type_reg", 8'h2b, rd);
    pkt(6'h2b, 1'b1);
    pkt(6'h1e, 1'b0);
    wr(8'h10, 8'h02);
    pkt(6'h1e, 1'b1);
    pkt(6'h12, 1'b0);
    wr(8'h10, 8'h01);
    pkt(6'h12, 1'b1);
    wr(8'h03, 8'h10);
    pkt(6'h2c, 1'b0);
    rg(8'h20);
    chk("unmapped", 8'h00, rd);
    wr(8'h03, 8'h00);
    @(posedge clk);
    pwr <= 1'b0;
    strap <= 3'h0;
    addr_strap <= 1'b1;
    repeat (4) @(posedge clk);
    pwr <= 1'b1;
    repeat (4) @(posedge clk);
    rg(8'h03);
    chk("old_addr", 8'h00, {7'h0, ok});
    @(posedge clk);
    dev_addr <= 7'h19;
    rg(8'h03);
    chk("new_addr", 8'h01, {7'h0, ok});
    chk("restrap", 8'h00, {5'h00, rd[2:0]});
    chk("legacy_off", 8'h00, {7'h0, legacy});
    close_out();
  end
endmodule // tb_top
`default_nettype wire
